// >>> ucesr_regs.sv
// Purpose: uncore configuration register bank with error status and interrupt generation
// Assumes: event inputs are one-cycle pulses from logic on REF_CLK
// Notes: configuration answer comes one cycle after the request
`timescale 1ns/1ps
module ucesr_regs #(
	parameter int TRK_LIMIT = ucesr_pkg::TRK_TIMEOUT_CYCLES,
	// identifier values are arbitrary
	parameter logic [15:0] VENDOR_ID = 16'h1a2b,
	parameter logic [15:0] DEVICE_ID_F0 = 16'h0c01,
	parameter logic [15:0] DEVICE_ID_F2 = 16'h0c02
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// configuration access
	input wire logic CFG_REQ,
	input wire logic CFG_WR,
	input wire logic [2:0] CFG_FUNC,
	input wire logic [11:0] CFG_ADDR,
	input wire logic [ucesr_pkg::LEN_W-1:0] CFG_LEN,
	input wire logic [31:0] CFG_WDATA,
	output logic CFG_ACK,
	output logic CFG_ABORT,
	output logic [31:0] CFG_RDATA,
	// message channel
	input wire logic [ucesr_pkg::TRK_SLOTS-1:0] MC_NP_REQ,
	input wire logic [ucesr_pkg::TRK_SLOTS-1:0] MC_NP_RSP,
	input wire logic MC_BAD_BCAST,
	input wire logic MC_CORE_MSG,
	// error indications
	input wire logic EV_LOCK_TIMEOUT,
	input wire logic EV_MGMT_TIMEOUT,
	input wire logic EV_BAD_OPCODE,
	input wire logic EV_POISON,
	input wire logic EV_MEMCTRL,
	input wire logic EV_LOCAL_MCHECK,
	// configuration outputs
	output logic MGMT_IRQ,
	output logic [23:0] GROUP_NODE_MAP,
	output logic [47:0] BUS_NUMBERS
);
	// byte lanes covered by an access
	function automatic logic [3:0] cfg_lanes(input logic [1:0] a, input logic [3:0] len);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < ucesr_pkg::DWORD_BYTES; i++) begin
			if (i >= int'(a) && i < int'(a) + int'(len)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : cfg_lanes

	// zero length, longer than a dword or crossing a dword boundary
	function automatic logic cfg_bad(input logic [1:0] a, input logic [3:0] len);
		logic [4:0] e;
		e = {3'h0, a} + {1'h0, len};
		return (len == 4'h0) || (e > 5'h04);
	endfunction : cfg_bad

	function automatic logic [31:0] lane_bits(input logic [3:0] l);
		logic [31:0] m;
		m = 32'h0;
		for (int i = 0; i < ucesr_pkg::DWORD_BYTES; i++) begin
			m[8*i +: 8] = {8{l[i]}};
		end
		return m;
	endfunction : lane_bits

	// replace writable bits under the enabled lanes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] bm, input logic [31:0] fm);
		logic [31:0] k;
		k = bm & fm;
		return (old & ~k) | (wd & k);
	endfunction : merge

	logic [31:0] err_reg;
	logic [31:0] err_next;
	logic [31:0] gmap_reg;
	logic [31:0] buslo_reg;
	logic [31:0] bushi_reg;
	logic [31:0] smictl_reg;
	logic irq_reg;
	logic ack_reg;
	logic abort_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rd_data;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	// message channel tracker
	ucesr_trk_if #(.N(ucesr_pkg::TRK_SLOTS)) trk ();
	assign trk.req = MC_NP_REQ;
	assign trk.rsp = MC_NP_RSP;
	ucesr_tracker #(.N(ucesr_pkg::TRK_SLOTS), .LIMIT(TRK_LIMIT)) u_trk (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.bus(trk)
	);

	// access decode
	wire logic misaligned = cfg_bad(CFG_ADDR[1:0], CFG_LEN);
	wire logic [31:0] bmask = lane_bits(cfg_lanes(CFG_ADDR[1:0], CFG_LEN));
	wire logic [9:0] dword = CFG_ADDR[11:2];
	wire logic f0 = CFG_FUNC == ucesr_pkg::FUNC_ERR;
	wire logic f2 = CFG_FUNC == ucesr_pkg::FUNC_BUS;
	wire logic wr_ok = CFG_REQ && CFG_WR && !misaligned;
	wire logic rd_ok = CFG_REQ && !CFG_WR && !misaligned;
	wire logic wr_mis = CFG_REQ && CFG_WR && misaligned;
	wire logic rd_mis = CFG_REQ && !CFG_WR && misaligned;
	wire logic wr_err = wr_ok && f0 && dword == ucesr_pkg::OFS_ERRSTS[11:2];
	wire logic wr_gmap = wr_ok && f0 && dword == ucesr_pkg::OFS_GMAP[11:2];
	wire logic wr_buslo = wr_ok && f2 && dword == ucesr_pkg::OFS_BUSLO[11:2];
	wire logic wr_bushi = wr_ok && f2 && dword == ucesr_pkg::OFS_BUSHI[11:2];
	wire logic wr_smictl = wr_ok && f2 && dword == ucesr_pkg::OFS_SMICTL[11:2];

	// interrupt generation
	wire logic dis_all = smictl_reg[ucesr_pkg::DIS_ALL];
	wire logic dis_err = smictl_reg[ucesr_pkg::DIS_ERR];
	wire logic dis_msg = smictl_reg[ucesr_pkg::DIS_MSG];
	wire logic dis_core = smictl_reg[ucesr_pkg::DIS_CORE];
	wire logic msg_event = (|trk.timeout) || MC_BAD_BCAST;
	wire logic err_event = EV_LOCK_TIMEOUT || wr_mis || rd_mis;
	wire logic irq_err = !dis_all && !dis_err && err_event;
	wire logic irq_msg = !dis_all && !dis_msg && msg_event;
	wire logic irq_core = !dis_all && !dis_core && MC_CORE_MSG;
	wire logic irq_memctrl = !dis_all && EV_MEMCTRL;
	wire logic irq_mcheck = !dis_all && EV_LOCAL_MCHECK;
	wire logic irq_fire = irq_err || irq_msg || irq_core || irq_memctrl || irq_mcheck;

	// error status events
	logic [31:0] err_set;
	always_comb begin
		err_set = 32'h0;
		err_set[ucesr_pkg::ERR_TKR_TO_LSB +: ucesr_pkg::ERR_TKR_TO_W] = trk.timeout;
		err_set[ucesr_pkg::ERR_TKR_ERR] = MC_BAD_BCAST;
		err_set[ucesr_pkg::ERR_DLV] = irq_fire;
		err_set[ucesr_pkg::ERR_LOCK_TO] = EV_LOCK_TIMEOUT;
		err_set[ucesr_pkg::ERR_MGMT_TO] = EV_MGMT_TIMEOUT;
		err_set[ucesr_pkg::ERR_WR_MIS] = wr_mis;
		err_set[ucesr_pkg::ERR_RD_MIS] = rd_mis;
		err_set[ucesr_pkg::ERR_BAD_OP] = EV_BAD_OPCODE;
		err_set[ucesr_pkg::ERR_POISON] = EV_POISON;
		err_set[ucesr_pkg::ERR_SRC_MC] = irq_memctrl;
		err_set[ucesr_pkg::ERR_SRC_MCHK] = irq_mcheck;
	end

	// software write then hardware set, so a set in the clearing cycle wins
	wire logic dlv_clr = wr_err && bmask[ucesr_pkg::ERR_DLV] && !CFG_WDATA[ucesr_pkg::ERR_DLV];
	wire logic [31:0] err_wr = wr_err ?
		merge(err_reg, CFG_WDATA, bmask, ucesr_pkg::ERR_RWS_MASK) : err_reg;
	assign err_next = (err_wr & ~(32'(dlv_clr) << ucesr_pkg::ERR_DLV)) | err_set;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			err_reg <= ucesr_pkg::ERR_RST;
		end else begin
			err_reg <= err_next;
		end
	end

	// control registers
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			gmap_reg <= ucesr_pkg::GMAP_RST;
			buslo_reg <= ucesr_pkg::BUSLO_RST;
			bushi_reg <= ucesr_pkg::BUSHI_RST;
			smictl_reg <= ucesr_pkg::SMICTL_RST;
		end else begin
			if (wr_gmap) begin
				gmap_reg <= merge(gmap_reg, CFG_WDATA, bmask, ucesr_pkg::GMAP_MASK);
			end
			if (wr_buslo) begin
				buslo_reg <= merge(buslo_reg, CFG_WDATA, bmask, ucesr_pkg::BUSLO_MASK);
			end
			if (wr_bushi) begin
				bushi_reg <= merge(bushi_reg, CFG_WDATA, bmask, ucesr_pkg::BUSHI_MASK);
			end
			if (wr_smictl) begin
				smictl_reg <= merge(smictl_reg, CFG_WDATA, bmask, ucesr_pkg::SMICTL_MASK);
			end
		end
	end

	// read selection
	always_comb begin
		rd_data = 32'h0;
		if (dword == ucesr_pkg::OFS_VENDOR_ID[11:2] && (f0 || f2)) begin
			rd_data[15:0] = VENDOR_ID;
			rd_data[ucesr_pkg::DEVID_POS +: 16] = f0 ? DEVICE_ID_F0 : DEVICE_ID_F2;
		end else if (f0) begin
			case (dword)
				ucesr_pkg::OFS_ERRSTS[11:2]: begin
					rd_data = err_reg;
				end
				ucesr_pkg::OFS_GMAP[11:2]: begin
					rd_data = gmap_reg;
				end
				default: begin
					rd_data = 32'h0;
				end
			endcase
		end else if (f2) begin
			case (dword)
				ucesr_pkg::OFS_BUSLO[11:2]: begin
					rd_data = buslo_reg;
				end
				ucesr_pkg::OFS_BUSHI[11:2]: begin
					rd_data = bushi_reg;
				end
				ucesr_pkg::OFS_SMICTL[11:2]: begin
					rd_data = smictl_reg;
				end
				default: begin
					rd_data = 32'h0;
				end
			endcase
		end
	end

	// answer and interrupt request
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_reg <= 1'b0;
			abort_reg <= 1'b0;
			rdata_reg <= 32'h0;
			irq_reg <= 1'b0;
		end else begin
			ack_reg <= CFG_REQ;
			abort_reg <= CFG_REQ && misaligned;
			rdata_reg <= rd_ok ? rd_data : 32'h0;
			irq_reg <= irq_fire;
		end
	end

	assign CFG_ACK = ack_reg;
	assign CFG_ABORT = abort_reg;
	assign CFG_RDATA = rdata_reg;
	assign MGMT_IRQ = irq_reg;
	assign GROUP_NODE_MAP = gmap_reg[ucesr_pkg::GMAP_GROUPS*ucesr_pkg::GMAP_FIELD_W-1:0];
	assign BUS_NUMBERS = {bushi_reg[15:0], buslo_reg};

	// checks
	a_abort_misaligned: assert property (CFG_REQ && misaligned
		|=> CFG_ABORT && CFG_RDATA == 32'h0)
		else $error("misaligned access not aborted");
	a_abort_cause: assert property (CFG_ABORT |-> $past(misaligned) && $past(CFG_REQ))
		else $error("abort without misaligned access");
	a_wr_misalign_flag: assert property (wr_mis |=> err_reg[ucesr_pkg::ERR_WR_MIS])
		else $error("write misalign flag not set");
	a_rd_misalign_flag: assert property (rd_mis |=> err_reg[ucesr_pkg::ERR_RD_MIS])
		else $error("read misalign flag not set");
	a_tkr_err_flag: assert property (MC_BAD_BCAST |=> err_reg[ucesr_pkg::ERR_TKR_ERR])
		else $error("tracker error flag not set");
	a_delivery_valid: assert property (MGMT_IRQ |-> err_reg[ucesr_pkg::ERR_DLV])
		else $error("interrupt without delivery valid");
	a_sticky_hold: assert property (!wr_err
		|=> (err_reg & $past(err_reg)) == $past(err_reg))
		else $error("status bit lost without write");
	a_global_off: assert property (dis_all |=> !MGMT_IRQ)
		else $error("interrupt while globally disabled");
	a_err_src_off: assert property (dis_err
		&& !(irq_msg || irq_core || irq_memctrl || irq_mcheck) |=> !MGMT_IRQ)
		else $error("lock or misalign interrupt while disabled");
	a_msg_src_off: assert property (dis_msg
		&& !(irq_err || irq_core || irq_memctrl || irq_mcheck) |=> !MGMT_IRQ)
		else $error("message channel interrupt while disabled");
	a_core_src_off: assert property (dis_core
		&& !(irq_err || irq_msg || irq_memctrl || irq_mcheck) |=> !MGMT_IRQ)
		else $error("core message interrupt while disabled");
	a_mc_source: assert property (EV_MEMCTRL && !dis_all
		|=> MGMT_IRQ && err_reg[ucesr_pkg::ERR_SRC_MC])
		else $error("memory controller source not recorded");
	a_mcheck_source: assert property (EV_LOCAL_MCHECK && !dis_all
		|=> MGMT_IRQ && err_reg[ucesr_pkg::ERR_SRC_MCHK])
		else $error("machine check source not recorded");
	a_ident_read: assert property (rd_ok && f2 && dword == 10'h000
		|=> CFG_RDATA == {DEVICE_ID_F2, VENDOR_ID})
		else $error("identifier read wrong");
	a_trk_to_idle: assert property ((trk.timeout & trk.busy) == '0)
		else $error("tracker slot busy while timing out");
	a_bus_stable: assert property (!wr_buslo && !wr_bushi |=> $stable(BUS_NUMBERS))
		else $error("bus numbers changed without write");
endmodule : ucesr_regs

// >>> ucesr_pkg.sv
// Purpose: shared constants of the uncore config and error register bank
// Assumes: byte addressed configuration space, 32-bit dword data
// Notes: offsets are byte addresses inside a configuration function
package ucesr_pkg;
	// configuration functions
	localparam logic [2:0] FUNC_ERR = 3'h0;
	localparam logic [2:0] FUNC_BUS = 3'h2;
	// register offsets
	localparam logic [11:0] OFS_VENDOR_ID = 12'h000;
	localparam logic [11:0] OFS_DEVICE_ID = 12'h002;
	localparam logic [11:0] OFS_ERRSTS = 12'h0c8;
	localparam logic [11:0] OFS_BUSLO = 12'h0cc;
	localparam logic [11:0] OFS_BUSHI = 12'h0d0;
	localparam logic [11:0] OFS_GMAP = 12'h0d4;
	localparam logic [11:0] OFS_SMICTL = 12'h0d8;
	// access geometry
	localparam int LEN_W = 4;
	localparam int DWORD_BYTES = 4;
	localparam int DEVID_POS = 16;
	// error status fields
	localparam int ERR_TKR_TO_LSB = 18;
	localparam int ERR_TKR_TO_W = 6;
	localparam int ERR_TKR_ERR = 17;
	localparam int ERR_DLV = 16;
	localparam int ERR_LOCK_TO = 7;
	localparam int ERR_MGMT_TO = 6;
	localparam int ERR_WR_MIS = 5;
	localparam int ERR_RD_MIS = 4;
	localparam int ERR_BAD_OP = 3;
	localparam int ERR_POISON = 2;
	localparam int ERR_SRC_MC = 1;
	localparam int ERR_SRC_MCHK = 0;
	localparam logic [31:0] ERR_RST = 32'h00000000;
	localparam logic [31:0] ERR_RWS_MASK = 32'h00fe00ff;
	// group to node map
	localparam int GMAP_FIELD_W = 3;
	localparam int GMAP_GROUPS = 8;
	localparam logic [31:0] GMAP_RST = 32'h00000000;
	localparam logic [31:0] GMAP_MASK = 32'h00ffffff;
	// bus numbers
	localparam logic [31:0] BUSLO_RST = 32'h03020100;
	localparam logic [31:0] BUSLO_MASK = 32'hffffffff;
	localparam logic [31:0] BUSHI_RST = 32'h00000504;
	localparam logic [31:0] BUSHI_MASK = 32'h0000ffff;
	// interrupt generation control
	localparam int DIS_ALL = 25;
	localparam int DIS_ERR = 26;
	localparam int DIS_MSG = 27;
	localparam int DIS_CORE = 28;
	localparam logic [31:0] SMICTL_RST = 32'h04000000;
	localparam logic [31:0] SMICTL_MASK = 32'h1e000000;
	// message channel tracker
	localparam int TRK_SLOTS = 6;
	localparam int TRK_TIMEOUT_CYCLES = 4096;
	localparam int TRK_CNT_W = 13;
endpackage : ucesr_pkg

// >>> ucesr_trk_if.sv
// Purpose: carries tracker requests, responses and timeouts
// Assumes: one clock shared by both ends
// Notes: one bit per tracker slot
`timescale 1ns/1ps
interface ucesr_trk_if #(parameter int N = ucesr_pkg::TRK_SLOTS);
	logic [N-1:0] req;
	logic [N-1:0] rsp;
	logic [N-1:0] timeout;
	logic [N-1:0] busy;
	modport tracker(input req, input rsp, output timeout, output busy);
	modport owner(output req, output rsp, input timeout, input busy);
endinterface : ucesr_trk_if

// >>> ucesr_tracker.sv
// Purpose: times non-posted message channel requests per slot
// Assumes: request and response are one-cycle pulses per slot
// Notes: a new request in a slot restarts its timer
`timescale 1ns/1ps
module ucesr_tracker #(
	parameter int N = ucesr_pkg::TRK_SLOTS,
	parameter int LIMIT = ucesr_pkg::TRK_TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// slots
	ucesr_trk_if.tracker bus
);
	localparam int CW = ucesr_pkg::TRK_CNT_W;
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
	logic [CW-1:0] cnt_reg [N];
	logic [N-1:0] busy_reg;
	logic [N-1:0] to_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	assign bus.busy = busy_reg;
	assign bus.timeout = to_reg;

	for (genvar i = 0; i < N; i++) begin : g_slot
		wire logic expire = busy_reg[i] && !bus.req[i] && !bus.rsp[i] && cnt_reg[i] == LAST;
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				cnt_reg[i] <= '0;
				busy_reg[i] <= 1'b0;
				to_reg[i] <= 1'b0;
			end else begin
				to_reg[i] <= expire;
				if (bus.req[i]) begin
					busy_reg[i] <= 1'b1;
					cnt_reg[i] <= '0;
				end else if (bus.rsp[i] || expire) begin
					busy_reg[i] <= 1'b0;
				end else if (busy_reg[i]) begin
					cnt_reg[i] <= cnt_reg[i] + CW'(1);
				end
			end
		end
		a_trk_timeout_count: assert property (to_reg[i] |-> $past(cnt_reg[i]) == LAST)
			else $error("tracker timeout at wrong count");
		a_trk_rsp_cancel: assert property (bus.rsp[i] && !bus.req[i] |=> !busy_reg[i] && !to_reg[i])
			else $error("response did not cancel tracker slot");
	end
endmodule : ucesr_tracker

// >>> ucesr_host.sv
// Purpose: host firmware model issuing configuration reads and writes
// Assumes: one request in flight, answer on the next clock edge
// Notes: address and data lines are scrambled while idle
`timescale 1ns/1ps
module ucesr_host (
	// clock
	input wire logic clk,
	// request
	output logic req,
	output logic wr,
	output logic [2:0] func,
	output logic [11:0] addr,
	output logic [3:0] len,
	output logic [31:0] wdata,
	// answer
	input wire logic ack,
	input wire logic abort,
	input wire logic [31:0] rdata
);
	initial begin
		req = 1'b0;
		wr = 1'b0;
		func = 3'h0;
		addr = 12'h000;
		len = 4'h4;
		wdata = 32'h00000000;
	end

	// one access; length and lane are used as commanded by the caller
	task automatic acc(input logic w, input logic [2:0] f, input logic [11:0] a,
		input logic [3:0] l, input logic [31:0] d, output logic [31:0] rd,
		output logic ab, output logic ok);
		@(negedge clk);
		req = 1'b1;
		wr = w;
		func = f;
		addr = a;
		len = l;
		wdata = d;
		@(negedge clk);
		ok = ack;
		ab = abort;
		rd = rdata;
		req = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
	endtask : acc
endmodule : ucesr_host

// >>> ucesr_regs_tb.sv
// Purpose: self-checking bench for the uncore config and error register bank
// Assumes: tracker limit shortened to 8 cycles
// Notes: host model issues config accesses, bench drives event pulses
`timescale 1ns/1ps
module ucesr_regs_tb;
	localparam int LIM = 8;
	// event order: lock, mgmt, opcode, poison, memctrl, mcheck, bcast, core
	localparam logic [31:0] EB [8] = '{32'h80, 32'h40, 32'h08, 32'h04, 32'h02, 32'h01,
		32'h20000, 32'h0};
	localparam logic [7:0] ES = 8'b11110001;
	localparam logic [31:0] DC [4] = '{32'h02000000, 32'h04000000, 32'h08000000, 32'h10000000};
	localparam int DE [4] = '{4, 0, 6, 7};
	localparam logic [31:0] DS [4] = '{32'h0, 32'h80, 32'h20000, 32'h0};
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic req, wr, ack, abort, irq;
	logic [2:0] func;
	logic [11:0] addr;
	logic [3:0] len;
	logic [31:0] wdata, rdata, m;
	logic [5:0] np_req = 6'h00;
	logic [5:0] np_rsp = 6'h00;
	logic [7:0] ev = 8'h00;
	logic [23:0] gmap;
	logic [47:0] busn;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;

	ucesr_regs #(.TRK_LIMIT(LIM)) uut (.REF_CLK(ref_clk), .RST_B(rst_b), .CFG_REQ(req),
		.CFG_WR(wr), .CFG_FUNC(func), .CFG_ADDR(addr), .CFG_LEN(len), .CFG_WDATA(wdata),
		.CFG_ACK(ack), .CFG_ABORT(abort), .CFG_RDATA(rdata), .MC_NP_REQ(np_req),
		.MC_NP_RSP(np_rsp), .MC_BAD_BCAST(ev[6]), .MC_CORE_MSG(ev[7]),
		.EV_LOCK_TIMEOUT(ev[0]), .EV_MGMT_TIMEOUT(ev[1]), .EV_BAD_OPCODE(ev[2]),
		.EV_POISON(ev[3]), .EV_MEMCTRL(ev[4]), .EV_LOCAL_MCHECK(ev[5]), .MGMT_IRQ(irq),
		.GROUP_NODE_MAP(gmap), .BUS_NUMBERS(busn));
	ucesr_host host (.clk(ref_clk), .req(req), .wr(wr), .func(func), .addr(addr),
		.len(len), .wdata(wdata), .ack(ack), .abort(abort), .rdata(rdata));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [2:0] f, input logic [11:0] a,
		input logic [3:0] l, input logic [31:0] d, input logic [31:0] exp, input logic eab);
		logic [31:0] rd;
		logic ab, ok;
		host.acc(w, f, a, l, d, rd, ab, ok);
		chk(ok, 1'b1);
		chk(ab, eab);
		chk(rd, exp);
	endtask : acc

	task automatic rdc(input logic [2:0] f, input logic [11:0] a, input logic [31:0] exp);
		acc(1'b0, f, a, 4'h4, 32'h0, exp, 1'b0);
	endtask : rdc

	task automatic wrc(input logic [2:0] f, input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, f, a, 4'h4, d, 32'h0, 1'b0);
	endtask : wrc

	task automatic pulse(input int i, input logic eirq);
		@(negedge ref_clk);
		ev[i] = 1'b1;
		@(negedge ref_clk);
		ev[i] = 1'b0;
		chk(irq, eirq);
	endtask : pulse

	task automatic t_reset();
		rdc(3'h0, 12'h000, 32'h0c011a2b);
		rdc(3'h2, 12'h000, 32'h0c021a2b);
		wrc(3'h0, 12'h000, 32'h0);
		rdc(3'h0, 12'h000, 32'h0c011a2b);
		rdc(3'h0, 12'h0c8, 32'h0);
		rdc(3'h0, 12'h0d4, 32'h0);
		rdc(3'h2, 12'h0cc, 32'h03020100);
		rdc(3'h2, 12'h0d0, 32'h00000504);
		rdc(3'h2, 12'h0d8, 32'h04000000);
		chk(busn, 48'h050403020100);
		rdc(3'h2, 12'h0c8, 32'h0);
		rdc(3'h5, 12'h000, 32'h0);
	endtask : t_reset

	task automatic t_regs();
		wrc(3'h0, 12'h0d4, 32'hffffffff);
		rdc(3'h0, 12'h0d4, 32'h00ffffff);
		m = 32'h0;
		for (int g = 0; g < 8; g++) begin
			m[3*g +: 3] = 3'(g);
		end
		wrc(3'h0, 12'h0d4, m);
		chk(gmap, m[23:0]);
		acc(1'b1, 3'h0, 12'h0d5, 4'h1, 32'h0, 32'h0, 1'b0);
		rdc(3'h0, 12'h0d4, m & 32'hffff00ff);
		wrc(3'h2, 12'h0cc, 32'haabbccdd);
		wrc(3'h2, 12'h0d0, 32'hffffffff);
		rdc(3'h2, 12'h0d0, 32'h0000ffff);
		chk(busn, 48'hffffaabbccdd);
	endtask : t_regs

	task automatic t_mis();
		logic [11:0] a [4] = '{12'h0c8, 12'h0c8, 12'h0d5, 12'h0d7};
		logic [3:0] l [4] = '{4'h0, 4'h5, 4'h4, 4'h2};
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 3'h0, a[i], l[i], 32'h0, 32'h0, 1'b1);
		end
		rdc(3'h0, 12'h0c8, 32'h10);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 3'h0, a[i], l[i], 32'hffffffff, 32'h0, 1'b1);
		end
		chk(gmap, m[23:0] & 24'hff00ff);
		acc(1'b0, 3'h0, 12'h0ca, 4'h2, 32'h0, 32'h30, 1'b0);
		wrc(3'h0, 12'h0c8, 32'h0);
		wrc(3'h2, 12'h0d8, 32'h0);
		acc(1'b1, 3'h0, 12'h0d6, 4'h3, 32'h0, 32'h0, 1'b1);
		rdc(3'h0, 12'h0c8, 32'h10020);
	endtask : t_mis

	task automatic t_events();
		for (int i = 0; i < 8; i++) begin
			wrc(3'h0, 12'h0c8, 32'h0);
			pulse(i, ES[i]);
			rdc(3'h0, 12'h0c8, EB[i] | {15'h0, ES[i], 16'h0});
		end
		wrc(3'h0, 12'h0c8, 32'h0);
		pulse(3, 1'b0);
		pulse(2, 1'b0);
		pulse(4, 1'b1);
		rdc(3'h0, 12'h0c8, 32'h1000e);
		wrc(3'h0, 12'h0c8, 32'h0001000c);
		rdc(3'h0, 12'h0c8, 32'h1000c);
		wrc(3'h0, 12'h0c8, 32'h0000000c);
		rdc(3'h0, 12'h0c8, 32'h0000000c);
	endtask : t_events

	task automatic t_dis();
		wrc(3'h2, 12'h0d8, 32'hffffffff);
		rdc(3'h2, 12'h0d8, 32'h1e000000);
		for (int j = 0; j < 4; j++) begin
			wrc(3'h2, 12'h0d8, DC[j]);
			wrc(3'h0, 12'h0c8, 32'h0);
			pulse(DE[j], 1'b0);
			rdc(3'h0, 12'h0c8, DS[j]);
		end
	endtask : t_dis

	task automatic t_trk();
		wrc(3'h2, 12'h0d8, 32'h0);
		wrc(3'h0, 12'h0c8, 32'h0);
		@(negedge ref_clk);
		np_req = 6'h05;
		@(negedge ref_clk);
		np_req = 6'h00;
		np_rsp = 6'h01;
		@(negedge ref_clk);
		np_rsp = 6'h00;
		repeat (LIM - 1) @(negedge ref_clk);
		chk(irq, 1'b0);
		@(negedge ref_clk);
		chk(irq, 1'b1);
		rdc(3'h0, 12'h0c8, 32'h00110000);
	endtask : t_trk

	initial begin
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_b = 1'b1;
		t_reset();
		t_regs();
		t_mis();
		t_events();
		t_dis();
		t_trk();
		end_sim();
	end
endmodule : ucesr_regs_tb
